//--- rtl/srp_cfg.svh
// Constants shared by both ends of the SPI RAM access link.
// Assumes inclusion by bare name from any design file.
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH

// ***********************************
// Instruction codes
// ***********************************
`define SRP_RD_BYTE 8'h13
`define SRP_RD_ARRAY 8'h03
`define SRP_WR_BYTE 8'h12
`define SRP_WR_ARRAY 8'h02
`define SRP_IDLE_BYTE 8'h00

// ***********************************
// Address space
// ***********************************
`define SRP_TOP_4K 12'hfff
`define SRP_TOP_2K 12'h7ff
`define SRP_ADDR_ONE 16'h0001

// ***********************************
// Bit and edge counting
// ***********************************
`define SRP_BIT_LAST 3'h7
`define SRP_BIT_FIRST 3'h0
`define SRP_EDGE_LAST 4'hf
`define SRP_EDGE_FIRST 4'h0
`define SRP_DATA_INDEX 9'h003

// ***********************************
// Timing
// ***********************************
`define SRP_CLK_NS 20
// Half period must cover both two-flop synchronisers and the drive flop
`define SRP_SCK_HALF_NS 120

`endif

//--- rtl/srp_link_if.sv
// Four-wire serial link between host end and device end.
// Assumes the bench instantiates it and joins both ends.
`timescale 1ns/1ps
interface srp_link_if;
    // Serial clock, made by the host only
    logic sclk;
    // Slave select, active low
    logic slaveSelectN;
    // Host to device data
    logic mosi;
    // Device to host data and its drive enable
    logic miso;
    logic misoOe;
    // Resolved line level; undriven line reads low
    wire misoLine = misoOe ? miso : 1'b0;

    // Device end
    modport device (input sclk, input slaveSelectN, input mosi,
        output miso, output misoOe);
    // Host end
    modport host (output sclk, output slaveSelectN, output mosi,
        input misoLine);
endinterface

//--- rtl/srp_pkg.sv
// Types shared by both ends of the SPI RAM access link.
// Assumes nothing beyond a SystemVerilog compiler.
package srp_pkg;

    // ***********************************
    // State types
    // ***********************************
    // Device sequence through one selection
    typedef enum logic [2:0] {
        SRP_DS_INSTR = 3'h0,
        SRP_DS_ADDRH = 3'h1,
        SRP_DS_ADDRL = 3'h3,
        SRP_DS_DATA = 3'h2,
        SRP_DS_IGNORE = 3'h6
    } srp_dev_state_t;

    // Host sequence through one command
    typedef enum logic [2:0] {
        SRP_HS_IDLE = 3'h0,
        SRP_HS_LEAD = 3'h1,
        SRP_HS_XFER = 3'h3,
        SRP_HS_WAITD = 3'h2,
        SRP_HS_TRAIL = 3'h6
    } srp_host_state_t;

endpackage

//--- rtl/srp_spi_device.sv
// Device end: serial slave giving byte access to internal RAM.
// Assumes RAM answers rdValid within one cycle of rdReq.
// Contract
// - Host makes the clock; device never drives it
// - Phase picks odd or even sampling edges
// - Eight bit shifts exchange one byte each way
// - Phase 0: first bit ready at selection
// - Phase 1: first edge drives, second latches
// - Completed byte moves to holding register
// - Select high ends any sequence
// - First byte is instruction; 16-bit address register
// - All bytes travel most significant bit first
// - Read codes 0x13 single, 0x03 array
// - Write codes 0x12 single, 0x02 array
// - Upper address bits ignored per memory size
// - Addresses use one fixed byte order
// - Single read sends one byte, no increment
// - Array read increments per byte, keeps sending
// - Address wraps from top to zero
// - Single write stores one byte, ignores rest
// - Array write stores then increments
// - Host reads control area with single reads
// - Both ends share phase and polarity
`timescale 1ns/1ps
`include "srp_cfg.svh"
module srp_spi_device #(
    parameter int FIFO_DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    srp_link_if.device link,
    // Static straps from pins
    input wire logic clockPhaseSetting,
    input wire logic clockPolaritySetting,
    input wire logic mem4k,
    // RAM read port
    output logic rdReq,
    output logic [11:0] rdAddr,
    input wire logic rdValid,
    input wire logic [7:0] rdData,
    // RAM write stream
    output logic wrValid,
    output logic [11:0] wrAddr,
    output logic [7:0] wrData,
    input wire logic wrReady
);

    // ***********************************
    // Parameter check
    // ***********************************
    if (FIFO_DEPTH != 2) begin : gDepthCheck
        $error("srp_spi_device: FIFO_DEPTH must be 2");
    end

    // ***********************************
    // Address masking
    // ***********************************
    // Drop ignored upper bits; wrap follows from the width
    function automatic logic [11:0] maskAddr(input logic [15:0] a, input logic is4k);
        maskAddr = is4k ? (a[11:0] & `SRP_TOP_4K) : (a[11:0] & `SRP_TOP_2K);
    endfunction

    // ***********************************
    // Pin synchronisers
    // ***********************************
    logic [5:0] pinMeta; // First stage, read only by pinSync
    logic [5:0] pinSync; // Second stage, used by logic

    // Two flops on every pin input
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= 6'h10;
            pinSync <= 6'h10;
        end else begin
            pinMeta <= {link.sclk, link.slaveSelectN, link.mosi,
                clockPhaseSetting, clockPolaritySetting, mem4k};
            pinSync <= pinMeta;
        end
    end

    wire sckLevel = pinSync[5] ^ pinSync[1]; // Polarity only inverts
    wire selected = ~pinSync[4]; // Active-low select
    wire mosiBit = pinSync[3];
    wire phase = pinSync[2];
    wire is4k = pinSync[0];

    // ***********************************
    // Edge detection
    // ***********************************
    logic sckPrev; // Previous normalised clock level

    // Remember clock level for edge finding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sckPrev <= 1'b0;
        end else begin
            sckPrev <= sckLevel;
        end
    end

    wire leadEdge = selected & sckLevel & ~sckPrev; // Odd edges
    wire trailEdge = selected & ~sckLevel & sckPrev; // Even edges
    wire sampleEv = phase ? trailEdge : leadEdge;
    wire driveEv = phase ? leadEdge : trailEdge;

    // ***********************************
    // Receive shift and holding register
    // ***********************************
    logic [2:0] bitCnt; // Bits sampled in current byte
    logic [6:0] rxShift; // Bits received so far
    logic [7:0] rxHold; // Completed byte
    wire lastBit = bitCnt == `SRP_BIT_LAST;
    wire byteEnd = sampleEv & lastBit;
    wire [7:0] rxByte = {rxShift, mosiBit}; // MSB arrives first

    // Shift in on sampling edges; eight bits per byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt <= `SRP_BIT_FIRST;
            rxShift <= 7'h00;
        end else if (!selected) begin
            bitCnt <= `SRP_BIT_FIRST;
        end else if (sampleEv) begin
            bitCnt <= bitCnt + 3'h1;
            rxShift <= rxByte[6:0];
        end
    end

    // ***********************************
    // Instruction and address
    // ***********************************
    srp_pkg::srp_dev_state_t state, next_state;
    logic [7:0] instr; // Instruction register
    logic [15:0] addr; // Address register

    wire isRead = (instr == `SRP_RD_BYTE) || (instr == `SRP_RD_ARRAY);
    wire isSingle = (instr == `SRP_RD_BYTE) || (instr == `SRP_WR_BYTE);
    wire codeOk = (rxByte == `SRP_RD_BYTE) || (rxByte == `SRP_RD_ARRAY) ||
        (rxByte == `SRP_WR_BYTE) || (rxByte == `SRP_WR_ARRAY);
    wire inData = state == srp_pkg::SRP_DS_DATA;
    wire loadEv = driveEv & inData & isRead & (bitCnt == `SRP_BIT_FIRST);
    wire [11:0] incAddr = maskAddr(addr + `SRP_ADDR_ONE, is4k);
    // Low byte used as sent, no swapping
    wire [11:0] firstAddr = maskAddr({addr[15:8], rxByte}, is4k);
    wire firstRd = (state == srp_pkg::SRP_DS_ADDRL) & byteEnd & isRead;
    wire nextRd = loadEv & ~isSingle;

    // Sequence through one selection
    always_comb begin
        next_state = state;
        case (state)
            srp_pkg::SRP_DS_INSTR: begin
                if (byteEnd) begin
                    next_state = codeOk ? srp_pkg::SRP_DS_ADDRH : srp_pkg::SRP_DS_IGNORE;
                end
            end
            srp_pkg::SRP_DS_ADDRH: begin
                if (byteEnd) begin
                    next_state = srp_pkg::SRP_DS_ADDRL;
                end
            end
            srp_pkg::SRP_DS_ADDRL: begin
                if (byteEnd) begin
                    next_state = srp_pkg::SRP_DS_DATA;
                end
            end
            srp_pkg::SRP_DS_DATA: begin
                if (byteEnd && isSingle) begin
                    next_state = srp_pkg::SRP_DS_IGNORE;
                end
            end
            srp_pkg::SRP_DS_IGNORE: next_state = srp_pkg::SRP_DS_IGNORE;
            default: next_state = srp_pkg::SRP_DS_INSTR;
        endcase
        if (!selected) begin
            next_state = srp_pkg::SRP_DS_INSTR;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= srp_pkg::SRP_DS_INSTR;
        end else begin
            state <= next_state;
        end
    end

    // Capture instruction and address bytes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr <= `SRP_IDLE_BYTE;
            addr <= 16'h0000;
        end else if (byteEnd) begin
            case (state)
                srp_pkg::SRP_DS_INSTR: instr <= rxByte;
                srp_pkg::SRP_DS_ADDRH: addr[15:8] <= rxByte;
                srp_pkg::SRP_DS_ADDRL: addr[7:0] <= rxByte;
                srp_pkg::SRP_DS_DATA: begin
                    if (!isRead && !isSingle) begin
                        addr <= {4'h0, incAddr};
                    end
                end
                default: addr <= addr;
            endcase
        end else if (nextRd) begin
            addr <= {4'h0, incAddr};
        end
    end

    // ***********************************
    // RAM read and transmit
    // ***********************************
    logic [7:0] txHold; // Prefetched byte
    logic [6:0] txShift; // Bits still to send

    // Request bytes ahead of their first drive edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdReq <= 1'b0;
            rdAddr <= 12'h000;
            txHold <= `SRP_IDLE_BYTE;
        end else begin
            rdReq <= firstRd | nextRd;
            if (firstRd) begin
                rdAddr <= firstAddr;
            end else if (nextRd) begin
                rdAddr <= incAddr;
            end
            if (rdValid) begin
                txHold <= rdData;
            end
        end
    end

    // Drive MISO; MSB first, load at each byte start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txShift <= 7'h00;
            link.miso <= 1'b0;
            link.misoOe <= 1'b0;
        end else begin
            link.misoOe <= selected & inData & isRead & (link.misoOe | loadEv);
            if (loadEv) begin
                link.miso <= txHold[7];
                txShift <= txHold[6:0];
            end else if (driveEv && inData && isRead) begin
                link.miso <= txShift[6];
                txShift <= {txShift[5:0], 1'b0};
            end
        end
    end

    // ***********************************
    // Write path with two-entry buffer
    // ***********************************
    logic pendValid; // Held byte waits for buffer space
    logic [11:0] pendAddr;
    logic tailValid;
    logic [11:0] tailAddr;
    logic [7:0] tailData;
    wire writeByte = byteEnd & inData & ~isRead;
    wire push = pendValid & ~tailValid; // Stalls while buffer is full
    wire pop = wrValid & wrReady;

    // Holding register for the completed byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxHold <= `SRP_IDLE_BYTE;
            pendAddr <= 12'h000;
            pendValid <= 1'b0;
        end else if (writeByte) begin
            rxHold <= rxByte;
            pendAddr <= maskAddr(addr, is4k);
            pendValid <= 1'b1;
        end else if (push) begin
            pendValid <= 1'b0;
        end
    end

    // Head feeds the ports; tail catches a byte during a stall
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrValid <= 1'b0;
            wrAddr <= 12'h000;
            wrData <= `SRP_IDLE_BYTE;
            tailValid <= 1'b0;
            tailAddr <= 12'h000;
            tailData <= `SRP_IDLE_BYTE;
        end else if (pop && tailValid) begin
            wrAddr <= tailAddr;
            wrData <= tailData;
            tailValid <= 1'b0;
        end else if (pop) begin
            wrValid <= push;
            wrAddr <= pendAddr;
            wrData <= rxHold;
        end else if (push && !wrValid) begin
            wrValid <= 1'b1;
            wrAddr <= pendAddr;
            wrData <= rxHold;
        end else if (push) begin
            tailValid <= 1'b1;
            tailAddr <= pendAddr;
            tailData <= rxHold;
        end
    end

endmodule

//--- rtl/srp_spi_host.sv
// Host end: serial master issuing read and write commands.
// Assumes command and data ports are driven from the clk domain.
`timescale 1ns/1ps
`include "srp_cfg.svh"
module srp_spi_host #(
    parameter int HALF_CYCLES = (`SRP_SCK_HALF_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    srp_link_if.host link,
    // Clock format
    input wire logic clockPhaseSetting,
    input wire logic clockPolaritySetting,
    // Command port
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [7:0] cmdInstr,
    input wire logic [15:0] cmdAddr,
    input wire logic [7:0] cmdLen,
    // Write data stream
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    // Read data out
    output logic rxValid,
    output logic [7:0] rxData,
    output logic busy
);

    // ***********************************
    // Parameter check
    // ***********************************
    // Below six the returning data bit misses its sampling edge
    if (HALF_CYCLES < 6 || HALF_CYCLES > 255) begin : gHalfCheck
        $error("srp_spi_host: HALF_CYCLES must be 6 to 255");
    end

    // ***********************************
    // MISO synchroniser
    // ***********************************
    logic misoMeta; // Read only by misoSync
    logic misoSync;

    // Two flops on the returning data line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            misoMeta <= 1'b0;
            misoSync <= 1'b0;
        end else begin
            misoMeta <= link.misoLine;
            misoSync <= misoMeta;
        end
    end

    // ***********************************
    // Half-period divider
    // ***********************************
    srp_pkg::srp_host_state_t state;
    logic [7:0] divCnt;
    wire running = (state == srp_pkg::SRP_HS_LEAD) || (state == srp_pkg::SRP_HS_XFER) ||
        (state == srp_pkg::SRP_HS_TRAIL);
    wire tick = running && (divCnt == 8'(HALF_CYCLES - 1));

    // One-cycle enable every half serial clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= 8'h00;
        end else if (!running || tick) begin
            divCnt <= 8'h00;
        end else begin
            divCnt <= divCnt + 8'h01;
        end
    end

    // ***********************************
    // Byte sequencing
    // ***********************************
    logic [7:0] instr;
    logic [15:0] addr;
    logic [8:0] byteIdx; // Bytes finished in this command
    logic [8:0] total; // Instruction, two address bytes, data
    logic [3:0] edgeCnt; // Edge within current byte
    logic [7:0] txSh;
    logic [7:0] rxSh; // Eight samples in phase 0, seven before the last in phase 1
    wire isWrite = (instr == `SRP_WR_BYTE) || (instr == `SRP_WR_ARRAY);
    wire lead = ~edgeCnt[0]; // Odd edges, counted from one
    wire sampleHere = clockPhaseSetting ? ~lead : lead;
    wire byteLast = tick && (state == srp_pkg::SRP_HS_XFER) && (edgeCnt == `SRP_EDGE_LAST);
    wire [8:0] nextIdx = byteIdx + 9'h001;
    wire needData = isWrite && (nextIdx >= `SRP_DATA_INDEX);
    wire [7:0] nextByte = (nextIdx == 9'h001) ? addr[15:8] :
        (nextIdx == 9'h002) ? addr[7:0] : `SRP_IDLE_BYTE;

    // Command flow, clock, select and data lines
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= srp_pkg::SRP_HS_IDLE;
            cmdReady <= 1'b0;
            txReady <= 1'b0;
            rxValid <= 1'b0;
            rxData <= `SRP_IDLE_BYTE;
            busy <= 1'b0;
            instr <= `SRP_IDLE_BYTE;
            addr <= 16'h0000;
            byteIdx <= 9'h000;
            total <= 9'h000;
            edgeCnt <= `SRP_EDGE_FIRST;
            txSh <= `SRP_IDLE_BYTE;
            rxSh <= 8'h00;
            link.sclk <= 1'b0;
            link.slaveSelectN <= 1'b1;
            link.mosi <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            cmdReady <= (state == srp_pkg::SRP_HS_IDLE) && !(cmdValid && cmdReady);
            case (state)
                srp_pkg::SRP_HS_IDLE: begin
                    link.sclk <= clockPolaritySetting; // Idle level
                    if (cmdValid && cmdReady) begin
                        instr <= cmdInstr;
                        addr <= cmdAddr;
                        total <= {1'b0, cmdLen} + `SRP_DATA_INDEX;
                        byteIdx <= 9'h000;
                        txSh <= cmdInstr;
                        link.mosi <= cmdInstr[7]; // First bit ready at selection
                        link.slaveSelectN <= 1'b0;
                        busy <= 1'b1;
                        state <= srp_pkg::SRP_HS_LEAD;
                    end
                end
                srp_pkg::SRP_HS_LEAD: begin
                    if (tick) begin
                        edgeCnt <= `SRP_EDGE_FIRST;
                        state <= srp_pkg::SRP_HS_XFER;
                    end
                end
                srp_pkg::SRP_HS_XFER: begin
                    if (tick) begin
                        link.sclk <= ~link.sclk; // Host alone makes the clock
                        edgeCnt <= edgeCnt + 4'h1;
                        if (sampleHere) begin
                            rxSh <= {rxSh[6:0], misoSync};
                        end
                        if (clockPhaseSetting && lead) begin
                            link.mosi <= txSh[7]; // Phase 1 drives on odd edges
                            txSh <= {txSh[6:0], 1'b0};
                        end else if (!clockPhaseSetting && !lead) begin
                            link.mosi <= txSh[6]; // Phase 0 shifts on even edges
                            txSh <= {txSh[6:0], 1'b0};
                        end
                    end
                    if (byteLast) begin
                        byteIdx <= nextIdx;
                        if (!isWrite && byteIdx >= `SRP_DATA_INDEX) begin
                            rxValid <= 1'b1;
                            // Phase 0 holds all eight bits; phase 1 takes the last one now
                            rxData <= clockPhaseSetting ? {rxSh[6:0], misoSync} : rxSh;
                        end
                        if (nextIdx == total) begin
                            state <= srp_pkg::SRP_HS_TRAIL;
                        end else if (needData) begin
                            txReady <= 1'b1;
                            state <= srp_pkg::SRP_HS_WAITD;
                        end else begin
                            txSh <= nextByte;
                            link.mosi <= clockPhaseSetting ? link.mosi : nextByte[7];
                        end
                    end
                end
                srp_pkg::SRP_HS_WAITD: begin
                    // Clock pauses at idle level until data arrives
                    if (txValid && txReady) begin
                        txReady <= 1'b0;
                        txSh <= txData;
                        link.mosi <= clockPhaseSetting ? link.mosi : txData[7];
                        edgeCnt <= `SRP_EDGE_FIRST;
                        state <= srp_pkg::SRP_HS_LEAD;
                    end
                end
                srp_pkg::SRP_HS_TRAIL: begin
                    if (tick) begin
                        link.slaveSelectN <= 1'b1; // Select held for whole command
                        busy <= 1'b0;
                        state <= srp_pkg::SRP_HS_IDLE;
                    end
                end
                default: state <= srp_pkg::SRP_HS_IDLE;
            endcase
        end
    end

endmodule

//--- tb/spi_slave_ram_access_port_tb.sv
// Bench joining host end and device end, with a RAM model.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ps
`include "srp_cfg.svh"
module spi_slave_ram_access_port_tb;
    logic clk, cmdReady, txReady, rxValid, busy, rdReq, wrValid, arr, tookTx;
    logic rst_b = 1'b0, cpol = 1'b0, cpha = 1'b0, mem4k = 1'b0, cmdValid = 1'b0;
    logic txValid = 1'b1, rdValid = 1'b0, wrReady = 1'b0;
    logic [7:0] cmdInstr = 8'h00, cmdLen = 8'h00, txData = 8'h00, rdData = 8'h00;
    logic [7:0] rxData, wrData;
    logic [15:0] cmdAddr = 16'h0000;
    logic [11:0] rdAddr, wrAddr, top, ptr;
    logic [7:0] ram [0:4095];
    logic [7:0] shadow [0:4095];
    logic [19:0] qRx [$];
    logic [19:0] qWr [$];
    logic [31:0] seed = 32'h0000_002a;
    int wrLeft = 0, nErrors = 0, checksDone = 0;
    srp_link_if link ();
    srp_spi_host srp_spi_host_inst (.clk(clk), .rst_b(rst_b), .link(link),
        .clockPhaseSetting(cpha), .clockPolaritySetting(cpol), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdInstr(cmdInstr), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
        .txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid),
        .rxData(rxData), .busy(busy));
    srp_spi_device srp_spi_device_inst (.clk(clk), .rst_b(rst_b), .link(link),
        .clockPhaseSetting(cpha), .clockPolaritySetting(cpol), .mem4k(mem4k),
        .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData),
        .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .wrReady(wrReady));
    srp_link_checker srp_link_checker_inst (.clk(clk), .rst_b(rst_b), .sclk(link.sclk),
        .slaveSelectN(link.slaveSelectN), .mosi(link.mosi), .miso(link.miso),
        .misoOe(link.misoOe), .misoLine(link.misoLine));
    // Xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Compare and count
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        if (nErrors == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One command; read results noted before it starts
    task automatic run(input logic [7:0] ins, input logic [15:0] ad, input logic [7:0] len);
        logic [11:0] a;
        int i;
        a = ad[11:0] & top;
        ptr = a;
        arr = !ins[4];
        wrLeft = (ins == `SRP_WR_BYTE) ? 1 : ((ins == `SRP_WR_ARRAY) ? int'(len) : 0);
        for (i = 0; i < len && ins[0]; i++) begin
            qRx.push_back(20'(((arr || i == 0) && ins[1]) ? shadow[a] : 8'h00));
            a = arr ? ((a + 12'h001) & top) : a;
        end
        cmdInstr = ins;
        cmdAddr = ad;
        cmdLen = len;
        i = 0;
        while (cmdReady !== 1'b1 && i < 100) begin
            @(posedge clk);
            #1 i++;
        end
        cmdValid = 1'b1;
        @(posedge clk);
        #1 cmdValid = 1'b0;
        i = 0;
        while (busy === 1'b1 && i < 5000) begin
            @(posedge clk);
            #1 i++;
        end
        if (i >= 5000 || busy !== 1'b0) nErrors++;
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Watchdog
    initial begin
        #(20 * 60000);
        nErrors++;
        report_and_stop();
    end
    // Driver side: RAM answers, stalls, write data and its notes
    always @(posedge clk) begin
        tookTx = txReady === 1'b1 && txValid === 1'b1;
        if (tookTx && wrLeft > 0) begin
            qWr.push_back({ptr, txData});
            shadow[ptr] = txData;
            wrLeft--;
            ptr = arr ? ((ptr + 12'h001) & top) : ptr;
        end
        #1 rdValid = rdReq;
        rdData = ram[rdAddr];
        wrReady = |2'(rnd());
        // New write byte only once the offered one is taken
        if (tookTx || txValid !== 1'b1) begin
            txValid = |2'(rnd());
            txData = 8'(rnd());
        end
    end
    // Watcher: RAM writes and read bytes against notes
    always @(posedge clk) begin
        if (wrValid === 1'b1 && wrReady === 1'b1) begin
            check({wrAddr, wrData}, qWr.size() ? qWr.pop_front() : 20'hx_xxxx);
            ram[wrAddr] = wrData;
        end
        if (rxValid === 1'b1) check(20'(rxData), qRx.size() ? qRx.pop_front() : 20'hx_xxxx);
    end
    // Main sequence: every clock format, both memory sizes
    initial begin
        logic [15:0] a;
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'(rnd());
            shadow[i] = ram[i];
        end
        for (int m = 0; m < 4; m++) begin
            if (m > 0) repeat (10) @(posedge clk);
            #1 rst_b = 1'b0;
            {cpol, cpha} = 2'(m);
            mem4k = m[0] ^ m[1];
            top = mem4k ? `SRP_TOP_4K : `SRP_TOP_2K;
            repeat (5) @(posedge clk);
            #1 rst_b = 1'b1;
            repeat (4) @(posedge clk);
            #1 run(`SRP_WR_ARRAY, {4'(rnd()), 12'hffe}, 8'h03);
            run(`SRP_RD_BYTE, {4'(rnd()), 12'h000}, 8'h02);
            a = {4'(rnd()), 12'h100 | (12'(rnd()) & 12'h4ff)};
            run(`SRP_WR_BYTE, a, 8'h02);
            run(`SRP_RD_ARRAY, a, 8'h03);
            run((8'(rnd()) & 8'hfd) | 8'h01, a, 8'h02);
        end
        repeat (20) @(posedge clk);
        check(20'(qRx.size() + qWr.size()), 20'h0_0000);
        report_and_stop();
    end
endmodule

//--- tb/srp_link_checker.sv
// Checker on the serial link wires between both ends.
// Assumes the bench instantiates it beside the link.
`timescale 1ns/1ps
module srp_link_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link wires
    input wire logic sclk,
    input wire logic slaveSelectN,
    input wire logic mosi,
    input wire logic miso,
    input wire logic misoOe,
    input wire logic misoLine
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Deselected for a while
    sequence sIdle; slaveSelectN [*5]; endsequence
    // Clock held for a half period
    sequence sHold; $stable(sclk) [*5]; endsequence
    AST_SCK_HALF: assert property ($changed(sclk) |=> sHold)
        else $error("serial clock half period too short");
    AST_SCK_LEAD: assert property ($fell(slaveSelectN) |-> sHold)
        else $error("serial clock edge too soon after select");
    AST_SCK_DESEL: assert property (slaveSelectN && $past(slaveSelectN) && $past(rst_b, 2)
        |-> $stable(sclk))
        else $error("serial clock moved while deselected");
    AST_NO_OE_IDLE: assert property (sIdle |-> !misoOe)
        else $error("data line driven while deselected");
    AST_OE_DESEL: assert property ($rose(slaveSelectN) |-> ##[0:4] !misoOe)
        else $error("data line still driven after deselect");
    AST_OE_SEL: assert property ($rose(misoOe) |-> !slaveSelectN)
        else $error("data line driven without select");
    AST_SS_GAP: assert property ($rose(slaveSelectN) |=> slaveSelectN)
        else $error("select gap too short");
    AST_MISO_EDGE: assert property (misoOe && $past(misoOe) && !slaveSelectN
        && $changed(miso) |-> $past(sclk, 3) != $past(sclk, 4))
        else $error("data changed away from a driving edge");
endmodule
